// ==== rtl/egpio_pkg.sv ====
// Package: register map, field layout, reset values and carriers of the GPIO port
`default_nettype none
package egpio_pkg;
    // ========================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_DIRECTION = 8'h00;
    localparam logic [7:0] OFS_OUT_PULL  = 8'h04;
    localparam logic [7:0] OFS_LEVEL     = 8'h08;
    localparam logic [7:0] OFS_CLK_MODE  = 8'h0c;
    localparam logic [7:0] OFS_PRESC     = 8'h10;
    // ========================================
    // Widths, positions, reset values
    localparam int          PIN_COUNT    = 8;
    localparam int          PIN_CLK_OUT  = 0;
    localparam int          PIN_CLK_IN   = 1;
    localparam int          PIN_INPUT    = 3;
    localparam logic [7:0]  RST_DIR      = 8'h00;
    localparam logic [7:0]  RST_DATA     = 8'h00;
    localparam logic [1:0]  RST_CLK_MODE = 2'h0;
    localparam logic [7:0]  SMALL_PINS   = 8'h3f;
    localparam logic [7:0]  LARGE_PINS   = 8'hff;
    localparam logic [1:0]  DIV_EXT      = 2'h3;
    // ========================================
    // Clock source modes
    typedef enum logic [1:0] {
        CLK_INTERNAL = 2'b00,
        CLK_SQUARE   = 2'b01,
        CLK_CRYSTAL  = 2'b10,
        CLK_RC       = 2'b11
    } egpio_clk_type;
    // ========================================
    // Pin carrier: three signals per pin
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } egpio_pad_type;
endpackage : egpio_pkg
`default_nettype wire

// ==== rtl/egpio_clkdiv.sv ====
// Instruction clock enable derived from the external clock pin
`default_nettype none
module egpio_clkdiv
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire egpio_pkg::egpio_clk_type mode,
    input  wire logic                   ext_in,
    output logic                        instr_en
);
    logic       ext_d_r;
    logic [1:0] cnt_r;
    logic       rise;

    // ========================================
    // Rising edge of the external clock pin
    always_ff @(posedge sys_clk)
    begin
        if (rst) ext_d_r <= 1'b0;
        else     ext_d_r <= ext_in;
    end
    assign rise = ext_in & ~ext_d_r;

    // ========================================
    // Divide by four for crystal or RC, none for square clock
    always_ff @(posedge sys_clk)
    begin
        if (rst || mode == egpio_pkg::CLK_INTERNAL || mode == egpio_pkg::CLK_SQUARE)
            cnt_r <= 2'h0;
        else if (rise)
            cnt_r <= cnt_r + 2'h1;
    end

    always_comb
    begin
        case (mode)
            egpio_pkg::CLK_INTERNAL: instr_en = 1'b1;
            egpio_pkg::CLK_SQUARE:   instr_en = rise;
            default:                 instr_en = rise && cnt_r == egpio_pkg::DIV_EXT;
        endcase
    end

    // Judged against the pin's own history, not the edge detector's flop
    ext_edge_a: assert property (@(posedge sys_clk) disable iff (rst)
        (mode == egpio_pkg::CLK_SQUARE) |-> (instr_en == (ext_in && !$past(ext_in))))
        else $error("square clock not passed undivided");
endmodule : egpio_clkdiv
`default_nettype wire

// ==== rtl/egpio_port.sv ====
// Eight-pin GPIO port with AHB-Lite register slave and clock-pin takeover
// Function
// - Pin 3 is always an input with weak pull-up.
// - Each pin independently is hi-Z input, pull-up input, or push-pull output.
// - Direction bit 0 makes an input, 1 an output.
// - Output pins drive their data bit, 1 high, 0 low.
// - Input pins: data bit 0 hi-Z, 1 weak pull-up.
// - Direction and data registers read back the last written value.
// - Level register returns actual pin levels whatever the configuration.
// - Register bit n maps to pin n; pins 6 and 7 only on large package.
// - Reset clears port registers so every pin but pin 3 becomes hi-Z input.
// - Some pins serve an alternate function selected by on-chip hardware.
// - Clock mode 00 int, 01 square, 10 crystal, 11 RC; pin 1 used, pin 0 in crystal only.
// - Crystal and RC divide external clock by four; square clock undivided.
`default_nettype none
module egpio_port
#(
    parameter bit LARGE_PACKAGE = 1'b1
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe,
    output logic [7:0]       pin_pullup,
    output logic             instr_clk_en
);
    logic [7:0]               pin_direction_r;
    logic [7:0]               pin_output_pullup_r;
    logic [7:0]               pin_level_readback_r;
    egpio_pkg::egpio_clk_type clock_source_select_r;
    logic                     wr_pend_r;
    logic [7:0]               wr_addr_r;
    logic [7:0]               rd_word;
    egpio_pkg::egpio_pad_type pad_nxt;
    egpio_pkg::egpio_pad_type pad_r;
    logic                     div_en;
    logic [7:0]               present;
    logic                     addr_take;

    // ========================================
    // Address decode helper
    function automatic logic [7:0] read_mux(input logic [7:0] a,
                                            input logic [7:0] dir,
                                            input logic [7:0] dat,
                                            input logic [7:0] lvl,
                                            input logic [1:0] cm);
        case (a)
            egpio_pkg::OFS_DIRECTION: read_mux = dir;
            egpio_pkg::OFS_OUT_PULL:  read_mux = dat;
            egpio_pkg::OFS_LEVEL:     read_mux = lvl;
            egpio_pkg::OFS_CLK_MODE:  read_mux = {6'h00, cm};
            default:                  read_mux = 8'h00;        // Unmapped reads zero
        endcase
    endfunction

    assign present   = LARGE_PACKAGE ? egpio_pkg::LARGE_PINS : egpio_pkg::SMALL_PINS;
    assign addr_take = hsel && hready && htrans[1];

    // ========================================
    // AHB-Lite slave: zero wait states, always OKAY
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_r <= addr_take && hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (addr_take && !hwrite)
            hrdata <= {24'h000000, rd_word};
    end
    assign rd_word = read_mux(haddr[7:0], pin_direction_r, pin_output_pullup_r,
                              pin_level_readback_r, clock_source_select_r);

    // Single driver each; constant answers still come from flops
    always_ff @(posedge sys_clk)
    begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end

    // ========================================
    // Port configuration registers; all bits stored, even inert ones
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_direction_r     <= egpio_pkg::RST_DIR;
            pin_output_pullup_r <= egpio_pkg::RST_DATA;
        end
        else if (wr_pend_r)
        begin
            if (wr_addr_r == egpio_pkg::OFS_DIRECTION)
                pin_direction_r <= hwdata[7:0];
            if (wr_addr_r == egpio_pkg::OFS_OUT_PULL)
                pin_output_pullup_r <= hwdata[7:0];
        end
    end

    // Clock source; software-writable stand-in for the init-register field
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            clock_source_select_r <= egpio_clk_reset();
        else if (wr_pend_r && wr_addr_r == egpio_pkg::OFS_CLK_MODE)
            clock_source_select_r <= egpio_pkg::egpio_clk_type'(hwdata[1:0]);
    end

    function automatic egpio_pkg::egpio_clk_type egpio_clk_reset();
        egpio_clk_reset = egpio_pkg::egpio_clk_type'(egpio_pkg::RST_CLK_MODE);
    endfunction

    // ========================================
    // Live pin levels; inputs synchronous, absent pins read zero
    always_ff @(posedge sys_clk)
    begin
        if (rst) pin_level_readback_r <= 8'h00;
        else     pin_level_readback_r <= pin_in & present;
    end

    // ========================================
    // Per-pin pad decode
    generate
        for (genvar i = 0; i < egpio_pkg::PIN_COUNT; i++)
        begin : g_pad
            always_comb
            begin
                pad_nxt.out[i]  = pin_output_pullup_r[i];
                pad_nxt.oe[i]   = pin_direction_r[i];
                pad_nxt.pull[i] = ~pin_direction_r[i] & pin_output_pullup_r[i];
                if (!present[i] || i == egpio_pkg::PIN_INPUT)
                begin
                    pad_nxt.out[i]  = 1'b0;
                    pad_nxt.oe[i]   = 1'b0;
                    pad_nxt.pull[i] = (i == egpio_pkg::PIN_INPUT);
                end
                else if (i == egpio_pkg::PIN_CLK_IN &&
                         clock_source_select_r != egpio_pkg::CLK_INTERNAL)
                begin
                    pad_nxt.out[i]  = 1'b0;
                    pad_nxt.oe[i]   = 1'b0;
                    pad_nxt.pull[i] = 1'b0;
                end
                else if (i == egpio_pkg::PIN_CLK_OUT &&
                         clock_source_select_r == egpio_pkg::CLK_CRYSTAL)
                begin
                    pad_nxt.out[i]  = ~pin_in[egpio_pkg::PIN_CLK_IN];  // Inverter drive
                    pad_nxt.oe[i]   = 1'b1;
                    pad_nxt.pull[i] = 1'b0;
                end
            end
        end
    endgenerate

    // Registered pads: one cycle of latency buys glitch-free outputs
    // Pin 3 keeps its pull-up through reset, so it never floats
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pad_r.out  <= egpio_pkg::RST_DATA;
            pad_r.oe   <= egpio_pkg::RST_DIR;
            pad_r.pull <= 8'h01 << egpio_pkg::PIN_INPUT;
        end
        else
            pad_r <= pad_nxt;
    end
    assign pin_out    = pad_r.out;
    assign pin_oe     = pad_r.oe;
    assign pin_pullup = pad_r.pull;

    // ========================================
    // Instruction clock enable from the selected source
    egpio_clkdiv u_div
    (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .mode     (clock_source_select_r),
        .ext_in   (pin_in[egpio_pkg::PIN_CLK_IN]),
        .instr_en (div_en)
    );

    always_ff @(posedge sys_clk)
    begin
        if (rst) instr_clk_en <= 1'b0;
        else     instr_clk_en <= div_en;
    end

    // ========================================
    // Checks
    pin3_input_a: assert property (@(posedge sys_clk) disable iff (rst)
        !pin_oe[3] && pin_pullup[3])
        else $error("pin 3 not a pull-up input");
    out_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
        (pin_direction_r[2] && $stable(pin_direction_r) && $stable(pin_output_pullup_r))
        |=> (pin_oe[2] && pin_out[2] == $past(pin_output_pullup_r[2])))
        else $error("output pin not driving data bit");
    input_pull_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!pin_direction_r[4] && present[4]) |=> (!pin_oe[4] &&
        pin_pullup[4] == $past(pin_output_pullup_r[4])))
        else $error("input pull-up wrong");
    dir_select_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(pin_direction_r[5]) && LARGE_PACKAGE |=> pin_oe[5])
        else $error("direction bit not obeyed");
    reg_readback_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_pend_r && wr_addr_r == egpio_pkg::OFS_DIRECTION)
        |=> pin_direction_r == $past(hwdata[7:0]))
        else $error("direction write lost");
    // Skips the edge after reset, where the register still holds its reset zero
    level_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> pin_level_readback_r == ($past(pin_in) & present))
        else $error("level readback wrong");
    reset_hiz_a: assert property (@(posedge sys_clk)
        rst |=> (pin_oe == 8'h00 && pin_direction_r == 8'h00))
        else $error("reset left pin driven");
    absent_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
        !LARGE_PACKAGE |-> (pin_oe[7:6] == 2'b00))
        else $error("absent pin driven");
    clk_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clock_source_select_r != egpio_pkg::CLK_INTERNAL) [*2] |-> !pin_oe[1])
        else $error("clock input pin driven");

    out_cov_c:   cover property (@(posedge sys_clk) pin_oe[2] && pin_out[2]);
    pull_cov_c:  cover property (@(posedge sys_clk) !pin_oe[2] && pin_pullup[2]);
    xtal_cov_c:  cover property (@(posedge sys_clk) pin_oe[0] &&
                 clock_source_select_r == egpio_pkg::CLK_CRYSTAL);
    div_cov_c:   cover property (@(posedge sys_clk) instr_clk_en &&
                 clock_source_select_r == egpio_pkg::CLK_RC);
endmodule : egpio_port
`default_nettype wire

// ==== verif/egpio_pad_model.sv ====
// Behavioural model of the circuitry hanging on the eight port pins
`default_nettype none
module egpio_pad_model
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic [7:0]      pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_r = 8'h55;
    // ========================================
    // Floating pins wander each cycle so a stale level never passes
    always_ff @(posedge sys_clk)
    begin
        float_r <= ~float_r;
    end
    // Wire level: port driver first, then outside driver, then pull-up
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                         pin_pullup[i] ? 1'b1 : float_r[i];
        end
    end
endmodule // egpio_pad_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench of the GPIO port: registers, pins and clock pins
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, instr_clk_en;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  pin_lvl, pin_out, pin_oe, pin_pullup, ext_en, ext_val;
    int          fail_count, cmp_count, cyc;
    assign hready = hreadyout;
    egpio_port #(.LARGE_PACKAGE(1'b1)) dut_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .instr_clk_en(instr_clk_en));
    egpio_pad_model pad_u (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));
    // ========================================
    // Clock, and a watchdog so a stuck handshake cannot hang the run
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    // ========================================
    // Shared helpers
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Single word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic pins(input logic [7:0] oe, input logic [7:0] outv, input logic [7:0] pu);
        chk("pin_oe", {24'h0, oe}, {24'h0, pin_oe});
        chk("pin_out", {24'h0, outv}, {24'h0, pin_out & oe});
        chk("pin_pullup", {24'h0, pu}, {24'h0, pin_pullup});
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
    endtask
    // ========================================
    // Scenarios
    task automatic t_config();
        logic [7:0] dv [5] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'ha5};
        logic [7:0] pv [5] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h3c};
        for (int i = 0; i < 5; i++)
        begin
            ahb(1'b1, egpio_pkg::OFS_DIRECTION, {24'h0, dv[i]});
            ahb(1'b1, egpio_pkg::OFS_OUT_PULL, {24'h0, pv[i]});
            repeat (2) @(posedge sys_clk);
            rdchk("direction", egpio_pkg::OFS_DIRECTION, {24'h0, dv[i]});
            rdchk("out_pull", egpio_pkg::OFS_OUT_PULL, {24'h0, pv[i]});
            pins(dv[i] & 8'hf7, dv[i] & pv[i] & 8'hf7, (~dv[i] & pv[i]) | 8'h08);
        end
        $display("test config done");
    endtask
    task automatic t_level();
        ahb(1'b1, egpio_pkg::OFS_DIRECTION, 32'h0f);
        ahb(1'b1, egpio_pkg::OFS_OUT_PULL, 32'h05);
        ext_en <= 8'hf0;
        ext_val <= 8'ha0;
        repeat (4) @(posedge sys_clk);
        rdchk("level", egpio_pkg::OFS_LEVEL, 32'had);
        ext_val <= 8'h50;
        repeat (4) @(posedge sys_clk);
        rdchk("level", egpio_pkg::OFS_LEVEL, 32'h5d);
        ahb(1'b1, egpio_pkg::OFS_PRESC, 32'hff);
        rdchk("unmapped", egpio_pkg::OFS_PRESC, 32'h0);
        rdchk("direction", egpio_pkg::OFS_DIRECTION, 32'h0f);
        ext_en <= 8'h00;
        $display("test level done");
    endtask
    task automatic t_midreset();
        ahb(1'b1, egpio_pkg::OFS_DIRECTION, 32'hff);
        ahb(1'b1, egpio_pkg::OFS_OUT_PULL, 32'hff);
        ahb(1'b1, egpio_pkg::OFS_CLK_MODE, 32'h2);
        do_reset();
        repeat (2) @(posedge sys_clk);
        pins(8'h00, 8'h00, 8'h08);
        rdchk("direction", egpio_pkg::OFS_DIRECTION, 32'h0);
        rdchk("out_pull", egpio_pkg::OFS_OUT_PULL, 32'h0);
        rdchk("clk_mode", egpio_pkg::OFS_CLK_MODE, 32'h0);
        $display("test reset done");
    endtask
    // Outside driver gives pin 1 8 rising edges, lost while the port drives it; pin 0 and 1 configured as GPIO outputs first
    task automatic t_clock(input egpio_pkg::egpio_clk_type m, input logic [1:0] oe, input int n);
        int cnt = 0;
        do_reset();
        ahb(1'b1, egpio_pkg::OFS_DIRECTION, 32'h03);
        ahb(1'b1, egpio_pkg::OFS_CLK_MODE, {30'h0, m});
        ext_en <= 8'h02;
        ext_val <= 8'h00;
        repeat (3) @(posedge sys_clk);
        rdchk("clk_mode", egpio_pkg::OFS_CLK_MODE, {30'h0, m});
        chk("clk_pins_oe", {30'h0, oe}, {30'h0, pin_oe[1:0]});
        for (int i = 0; i < 40; i++)
        begin
            @(posedge sys_clk);
            if (i < 32 && i % 2 == 0)
                ext_val[1] <= ~ext_val[1];
            cnt += (instr_clk_en === 1'b1) ? 1 : 0;
        end
        chk("instr_pulses", n, cnt);
        ext_en <= 8'h00;
        $display("test clock mode %0d done", m);
    endtask
    // ========================================
    // Main sequence
    initial
    begin
        {hsel, hwrite, haddr, hwdata, htrans, ext_en, ext_val} = '0;
        hsize = 3'h2;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk("direction", egpio_pkg::OFS_DIRECTION, 32'h0);
        pins(8'h00, 8'h00, 8'h08);
        t_config();
        t_level();
        t_midreset();
        t_clock(egpio_pkg::CLK_INTERNAL, 2'b11, 40);
        t_clock(egpio_pkg::CLK_SQUARE, 2'b01, 8);
        t_clock(egpio_pkg::CLK_CRYSTAL, 2'b01, 2);
        t_clock(egpio_pkg::CLK_RC, 2'b01, 2);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
